// ---- logic/qrvs_trigger.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "qrvs_defines.svh"
module qrvs_trigger #(
   parameter int CW = 24
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Comparator decisions, mode pin and soft-start flag, asynchronous
   input wire logic demag_arm_cmp,
   input wire logic demag_trig_cmp,
   input wire logic cs_trip_cmp,
   input wire logic comp_high_cmp,
   input wire logic comp_below_burst_cmp,
   input wire logic comp_above_burst_cmp,
   input wire logic mode_select_pin,
   input wire logic soft_start_active,
   // Outputs
   output logic gate_on,
   output logic demag_pullup_en,
   output logic low_power
);
   localparam logic [CW-1:0] DMAX_NUM = CW'(`QRVS_DMAX_PCT);

   // Two-stage synchronisers for all comparator inputs
   logic [7:0] s1, s2;
   wire [7:0] async_in = {soft_start_active, mode_select_pin, comp_above_burst_cmp,
      comp_below_burst_cmp, comp_high_cmp, cs_trip_cmp, demag_trig_cmp, demag_arm_cmp};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= 8'h00;
         s2 <= 8'h00;
      end else begin
         s1 <= async_in;
         s2 <= s1;
      end
   end
   wire arm_s = s2[0];
   wire trig_s = s2[1];
   wire trip_s = s2[2];
   wire open_loop = s2[3];
   wire burst_low = s2[4];
   wire burst_high = s2[5];
   wire quasi_resonant = s2[6];
   wire fixed_frequency = !quasi_resonant;
   wire ss_s = s2[7];

   // Registers
   logic ctrl_enable;
   logic [CW-1:0] osc_period, blank_cyc, delay_cyc;
   wire wr = psel && penable && pwrite;
   wire rd_ctrl = paddr == `QRVS_APB_CTRL;
   wire rd_per = paddr == `QRVS_APB_PERIOD;
   wire rd_blk = paddr == `QRVS_APB_BLANK;
   wire rd_dly = paddr == `QRVS_APB_DELAY;
   wire rd_sts = paddr == `QRVS_APB_STATUS;
   wire mapped = rd_ctrl | rd_per | rd_blk | rd_dly | rd_sts;

   // Core state
   qrvs_pkg::qrvs_state_e st;
   logic [CW-1:0] osc_cnt, since_on, blank_cnt, dly_cnt;
   logic [6:0] ol_div;
   logic armed, trig_d, arm_d, burst_stop;
   wire [31:0] status = {25'h0, st == qrvs_pkg::QRVS_ON, burst_stop, armed, open_loop,
      quasi_resonant, burst_high, burst_low};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_enable <= 1'b0;
         osc_period <= CW'(`QRVS_OSC_PERIOD_CYC);
         blank_cyc <= CW'(`QRVS_BLANK_CYC);
         delay_cyc <= CW'(`QRVS_TON_DELAY_CYC);
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (wr && pready) begin
            if (rd_ctrl) ctrl_enable <= pwdata[0];
            if (rd_per) osc_period <= pwdata[CW-1:0];
            if (rd_blk) blank_cyc <= pwdata[CW-1:0];
            if (rd_dly) delay_cyc <= pwdata[CW-1:0];
         end
         if (psel && !penable) begin
            prdata <= rd_ctrl ? {31'h0, ctrl_enable} :
               rd_per ? 32'(osc_period) : rd_blk ? 32'(blank_cyc) :
               rd_dly ? 32'(delay_cyc) : rd_sts ? status : 32'h0000_0000;
         end
      end
   end

   wire osc_end = osc_cnt >= osc_period - CW'(1);
   wire ol_end = osc_end && (ol_div == 7'h7F);
   wire blanking = blank_cnt != '0;
   wire period_done = since_on >= osc_period;
   wire trig_fall = trig_d && !trig_s;
   wire arm_rise = arm_s && !arm_d;
   // Valid QR edge: armed, past period, past blanking
   wire qr_edge = quasi_resonant && armed && trig_fall && period_done && !blanking;
   // Forced turn-on at oscillator end, every 128th end in open-loop QR; QR retries only after full period
   wire force_on = open_loop && quasi_resonant ? ol_end : osc_end;
   wire ff_on = fixed_frequency && osc_end;
   wire qr_force = quasi_resonant && force_on && period_done && !blanking;
   wire run = ctrl_enable && !burst_stop;
   wire max_duty = fixed_frequency && (since_on * CW'(100) >= osc_period * DMAX_NUM);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= qrvs_pkg::QRVS_OFF;
         osc_cnt <= '0;
         since_on <= '0;
         blank_cnt <= '0;
         dly_cnt <= '0;
         ol_div <= 7'h00;
         armed <= 1'b0;
         trig_d <= 1'b0;
         arm_d <= 1'b0;
         burst_stop <= 1'b0;
         gate_on <= 1'b0;
         demag_pullup_en <= 1'b0;
         low_power <= 1'b0;
      end else begin
         trig_d <= trig_s;
         arm_d <= arm_s;
         osc_cnt <= osc_end ? '0 : osc_cnt + CW'(1);
         if (osc_end) ol_div <= ol_div + 7'h01;
         if (!period_done) since_on <= since_on + CW'(1);
         else if (st == qrvs_pkg::QRVS_ON) since_on <= since_on + CW'(1);
         if (blanking) blank_cnt <= blank_cnt - CW'(1);
         if (burst_low) burst_stop <= 1'b1;
         else if (burst_stop && burst_high) burst_stop <= 1'b0;
         if (arm_rise && !blanking) armed <= 1'b1;
         case (st)
            qrvs_pkg::QRVS_OFF: begin
               if (run && (ff_on || qr_force)) begin
                  st <= qrvs_pkg::QRVS_ON;
                  gate_on <= 1'b1;
                  since_on <= '0;
                  armed <= 1'b0;
               end else if (run && qr_edge) begin
                  st <= qrvs_pkg::QRVS_DLY;
                  dly_cnt <= delay_cyc;
                  armed <= 1'b0;
               end
            end
            qrvs_pkg::QRVS_DLY: begin
               if (!run) begin
                  st <= qrvs_pkg::QRVS_OFF;
               end else if (dly_cnt == '0) begin
                  st <= qrvs_pkg::QRVS_ON;
                  gate_on <= 1'b1;
                  since_on <= '0;
                  osc_cnt <= '0;
                  ol_div <= 7'h00;
               end else begin
                  dly_cnt <= dly_cnt - CW'(1);
               end
            end
            qrvs_pkg::QRVS_ON: begin
               if (trip_s || max_duty || !run) begin
                  st <= qrvs_pkg::QRVS_OFF;
                  gate_on <= 1'b0;
                  blank_cnt <= blank_cyc;
                  armed <= 1'b0;
               end
            end
            default: begin
               st <= qrvs_pkg::QRVS_OFF;
               gate_on <= 1'b0;
            end
         endcase
         // Pull-up only in off-time, never in soft-start
         demag_pullup_en <= open_loop && !ss_s && !(st == qrvs_pkg::QRVS_ON);
         low_power <= burst_stop;
      end
   end

   AST_TRIP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      st == qrvs_pkg::QRVS_ON && trip_s |=> !gate_on)
      else $error("gate stayed on after current trip");
   AST_BURST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      burst_stop |=> !gate_on || $past(st) == qrvs_pkg::QRVS_ON)
      else $error("gate on during burst stop");
   AST_PULLUP_SS: assert property (@(posedge pclk) disable iff (!presetn)
      ss_s |=> !demag_pullup_en)
      else $error("pull-up active in soft-start");
   AST_PULLUP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      demag_pullup_en |-> $past(st) != qrvs_pkg::QRVS_ON)
      else $error("pull-up during on-time");
   AST_BLANK: assert property (@(posedge pclk) disable iff (!presetn)
      st == qrvs_pkg::QRVS_OFF && blanking |=> st != qrvs_pkg::QRVS_DLY)
      else $error("trigger accepted in blanking");
   AST_EARLY: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(gate_on) && quasi_resonant |-> $past(period_done))
      else $error("turn-on before one period");
   AST_DUTY: assert property (@(posedge pclk) disable iff (!presetn)
      st == qrvs_pkg::QRVS_ON && max_duty |=> !gate_on)
      else $error("duty limit exceeded");
   AST_FF_ON: assert property (@(posedge pclk) disable iff (!presetn)
      st == qrvs_pkg::QRVS_OFF && run && ff_on |=> gate_on)
      else $error("fixed frequency missed cycle start");
endmodule // qrvs_trigger
`default_nettype wire

// ---- logic/qrvs_defines.svh ----
// Operation
// - Armed falling demag edge turns switch on
// - Trigger responds only after rising arm edge
// - Ignore demag edges during post-turnoff blanking
// - Oscillator starts at once; first cycle end turns on
// - Current trip turns switch off each cycle
// - Late valid edge turns on after delay, resets ramp
// - Edges before one period ignored
// - No arming: turn on at next cycle end
// - Late blanking end extends inhibit window
// - Open loop enables demag pull-up during off-time
// - Open-loop retrigger uses period times 128
// - Pull-up disabled during soft-start
// - Fixed frequency turns on every cycle start
// - Fixed frequency duty capped at 70 percent
// - Fixed frequency ignores demag for turn-on
// - Low control voltage stops switching, low power
// - Burst stop resumes above burst threshold
`ifndef QRVS_DEFINES_SVH
`define QRVS_DEFINES_SVH
`define QRVS_CLK_MHZ 100
`define QRVS_BLANK_NS 2500
`define QRVS_BLANK_CYC ((`QRVS_BLANK_NS * `QRVS_CLK_MHZ + 999) / 1000)
`define QRVS_OSC_PERIOD_CYC 667
`define QRVS_TON_DELAY_CYC 20
`define QRVS_OL_DIV 128
`define QRVS_DMAX_PCT 70
`define QRVS_APB_CTRL 12'h000
`define QRVS_APB_PERIOD 12'h004
`define QRVS_APB_BLANK 12'h008
`define QRVS_APB_DELAY 12'h00C
`define QRVS_APB_STATUS 12'h010
`define QRVS_CTRL_RST 32'h0000_0000
`endif

// ---- logic/qrvs_pkg.sv ----
package qrvs_pkg;
   typedef enum logic [2:0] {
      QRVS_OFF = 3'b001,
      QRVS_DLY = 3'b010,
      QRVS_ON = 3'b100
   } qrvs_state_e;
endpackage

// ---- dv/qrvs_switch_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module qrvs_switch_model (
   // Clock
   input wire logic pclk,
   // Gate side and scenario knobs
   input wire logic gate_on,
   input wire logic pull_en,
   input wire logic trip_on,
   input wire logic ring_on,
   // Comparator decisions
   output logic cs_trip_cmp,
   output logic demag_arm_cmp,
   output logic demag_trig_cmp
);
   int on_cnt = 0;
   int off_cnt = 0;
   always @(posedge pclk) begin
      on_cnt <= gate_on ? on_cnt + 1 : 0;
      off_cnt <= gate_on ? 0 : off_cnt + 1;
   end
   // Ramp meets setpoint after five on-cycles
   assign cs_trip_cmp = trip_on && on_cnt >= 5;
   // Pull-up pins the winding above arm level, no valley falls
   assign demag_arm_cmp = pull_en || (ring_on && !gate_on && off_cnt[2]);
   // Ringing above arm level is above trigger level too; valley is the fall
   assign demag_trig_cmp = demag_arm_cmp;
endmodule // qrvs_switch_model
`default_nettype wire

// ---- dv/qr_valley_skip_pwm_trigger_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module qr_valley_skip_pwm_trigger_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, clr = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, arm, trig, trip, gate_on, demag_pullup_en, low_power;
   logic c_high = 0, c_below = 0, c_above = 0, mode = 0, ss = 0, trip_on = 1, ring_on = 1;
   logic pu_seen = 0;
   int n_errors = 0, total_checks = 0, cyc = 0, n_on = 0, hi_len = 0, hi_max = 0;
   int gap = 0, gap_min = 9999;
   always #5 pclk = ~pclk;
   qrvs_trigger #(.CW(24)) qrvs_trigger_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .demag_arm_cmp(arm), .demag_trig_cmp(trig),
      .cs_trip_cmp(trip), .comp_high_cmp(c_high), .comp_below_burst_cmp(c_below),
      .comp_above_burst_cmp(c_above), .mode_select_pin(mode), .soft_start_active(ss),
      .gate_on(gate_on), .demag_pullup_en(demag_pullup_en), .low_power(low_power));
   qrvs_switch_model qrvs_switch_model_inst (.pclk(pclk), .gate_on(gate_on),
      .pull_en(demag_pullup_en), .trip_on(trip_on), .ring_on(ring_on), .cs_trip_cmp(trip),
      .demag_arm_cmp(arm), .demag_trig_cmp(trig));
   task automatic finish_test();
      $display("Checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Gate statistics; clr restarts a window
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         finish_test();
      end
      hi_len <= (gate_on === 1'b1) ? hi_len + 1 : 0;
      if (hi_len > hi_max) hi_max <= hi_len;
      if (demag_pullup_en === 1'b1) pu_seen <= 1;
      gap <= gap + 1;
      if (gate_on === 1'b1 && hi_len == 0) begin
         n_on <= n_on + 1;
         if (gap < gap_min) gap_min <= gap;
         gap <= 1;
      end
      if (clr) begin
         hi_max <= 0;
         gap_min <= 9999;
         n_on <= 0;
         pu_seen <= 0;
      end
   end
   task automatic bad(input string m);
      n_errors++;
      $display("Error at %0t: %s", $time, m);
   endtask
   task automatic chk1(input logic g, input logic e);
      total_checks++;
      if (g !== e) bad("flag mismatch");
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) bad("word mismatch");
   endtask
   task automatic chkr(input int v, input int lo, input int hi);
      total_checks++;
      if (v < lo || v > hi) $display("Error at %0t: count %0d out of range", $time, v);
      if (v < lo || v > hi) n_errors++;
   endtask
   // One APB transfer, idle cycle first so strobes never collide
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic window(input int n);
      @(posedge pclk);
      clr <= 1;
      @(posedge pclk);
      clr <= 0;
      repeat (n) @(posedge pclk);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      chk1(gate_on | demag_pullup_en | low_power, 1'b0);
      presetn <= 1;
      apb(0, 12'h004, 0);
      chk32(rd, 32'h0000_029B);
      apb(1, 12'h004, 32'h0000_0014);
      apb(1, 12'h008, 32'h0000_0003);
      apb(1, 12'h00C, 32'h0000_0002);
      apb(0, 12'h004, 0);
      chk32(rd, 32'h0000_0014);
      apb(0, 12'h020, 0);
      chk1(err, 1'b1);
      chk32(rd, 32'h0000_0000);
      window(100);
      chkr(n_on, 0, 0);
      apb(1, 12'h000, 32'h0000_0001);
      window(400);
      chkr(n_on, 19, 21);
      chkr(gap_min, 19, 21);
      chkr(hi_max, 1, 10);
      trip_on <= 0;
      window(400);
      // Cap is at least 70 percent of 20 cycles, below the full period
      chkr(hi_max, 14, 19);
      trip_on <= 1;
      c_below <= 1;
      repeat (20) @(posedge pclk);
      window(100);
      chkr(n_on, 0, 0);
      chk1(low_power, 1'b1);
      c_below <= 0;
      c_above <= 1;
      repeat (10) @(posedge pclk);
      window(100);
      chk1(low_power, 1'b0);
      chkr(n_on, 4, 6);
      c_above <= 0;
      mode <= 1;
      window(400);
      chkr(gap_min, 20, 60);
      chkr(n_on, 5, 20);
      ring_on <= 0;
      window(400);
      chkr(n_on, 8, 20);
      ring_on <= 1;
      c_high <= 1;
      ss <= 1;
      window(200);
      chk1(pu_seen, 1'b0);
      ss <= 0;
      window(6000);
      chk1(pu_seen, 1'b1);
      chkr(n_on, 1, 3);
      finish_test();
   end
endmodule // qr_valley_skip_pwm_trigger_tb
`default_nettype wire
